// File: hdl/core_regs_pkg.sv
// Register map, field positions and reset values of the core register set
package core_regs_pkg;
  localparam logic [7:0] stack_top_pointer_addr            = 8'h81;
  localparam logic [7:0] pointer0_low_addr                 = 8'h82;
  localparam logic [7:0] pointer0_high_addr                = 8'h83;
  localparam logic [7:0] pointer1_low_addr                 = 8'h84;
  localparam logic [7:0] pointer1_high_addr                = 8'h85;
  localparam logic [7:0] power_and_write_mode_control_addr = 8'h87;
  localparam logic [7:0] active_pointer_select_addr        = 8'h92;
  localparam logic [7:0] paged_data_upper_byte_addr        = 8'hc9;
  localparam logic [7:0] processor_status_flags_addr       = 8'hd0;
  localparam logic [7:0] accumulator_register_addr         = 8'he0;
  localparam logic [7:0] multiply_helper_addr              = 8'hf0;
  // Status flag positions
  localparam int carry_pos      = 7;
  localparam int half_carry_pos = 6;
  localparam int user_a_pos     = 5;
  localparam int bank_hi_pos    = 4;
  localparam int bank_lo_pos    = 3;
  localparam int overflow_pos   = 2;
  localparam int user_b_pos     = 1;
  localparam int parity_pos     = 0;
  // Power control positions and writable mask
  localparam int baud_double_pos = 7;
  localparam int code_write_pos  = 4;
  localparam logic [7:0] power_ctl_mask = 8'hfc;
  // Reset values
  localparam logic [7:0] stack_reset = 8'h07;
  localparam logic [7:0] reg_reset   = 8'h00;
  // Memory layout
  localparam logic [7:0] bit_area_base  = 8'h20;
  localparam logic [7:0] upper_ram_base = 8'h80;
  localparam int internal_data_ram_bytes = 256;
endpackage

// File: hdl/core_regs.sv
// Core register set, internal data RAM and address generation
`timescale 1ns/100ps
`default_nettype none
module core_regs
  import core_regs_pkg::*;
(
  input  wire logic        i_mclk,
  input  wire logic        i_sys_rst,
  // APB slave, byte address = register offset * 4
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // Execution unit side
  input  wire logic        i_ram_we,
  input  wire logic        i_ram_indirect,
  input  wire logic [7:0]  i_ram_addr,
  input  wire logic [7:0]  i_ram_wdata,
  input  wire logic        i_bit_we,
  input  wire logic [6:0]  i_bit_addr,
  input  wire logic        i_bit_wdata,
  input  wire logic [2:0]  i_work_reg_sel,
  input  wire logic        i_acc_we,
  input  wire logic [7:0]  i_acc_wdata,
  input  wire logic        i_helper_we,
  input  wire logic [7:0]  i_helper_wdata,
  input  wire logic        i_carry_we,
  input  wire logic        i_carry_in,
  input  wire logic        i_half_carry_we,
  input  wire logic        i_half_carry_in,
  input  wire logic        i_overflow_we,
  input  wire logic        i_overflow_in,
  input  wire logic        i_push,
  input  wire logic        i_pop,
  input  wire logic        i_ptr_we,
  input  wire logic [15:0] i_ptr_wdata,
  input  wire logic        i_paged_sel_one,
  output logic [7:0]       o_ram_rdata,
  output logic             o_bit_rdata,
  output logic [7:0]       o_work_reg_addr,
  output logic [7:0]       o_accumulator,
  output logic [7:0]       o_helper,
  output logic [7:0]       o_status,
  output logic [7:0]       o_stack_top,
  output logic [15:0]      o_active_data_pointer,
  output logic [15:0]      o_paged_external_data,
  output logic             o_external_move_to_code,
  output logic             o_baud_double
);

  // ==========================================================
  // Register state
  logic [7:0] internal_data_ram [internal_data_ram_bytes];
  logic [7:0] accumulator_register;
  logic [7:0] multiply_helper;
  logic [7:0] status_bits;
  logic [7:0] stack_top_pointer;
  logic [7:0] pointer0_low;
  logic [7:0] pointer0_high;
  logic [7:0] pointer1_low;
  logic [7:0] pointer1_high;
  logic [7:0] power_and_write_mode_control;
  logic       active_pointer_select;
  logic [7:0] paged_data_upper_byte;

  // ==========================================================
  // APB decode
  logic [7:0] reg_addr;
  logic       apb_wr;
  logic       apb_rd;
  logic       mapped;
  logic [7:0] wbyte;
  logic [7:0] next_rdata;

  assign reg_addr = paddr[9:2];
  assign wbyte    = pwdata[7:0];
  assign apb_wr   = psel && penable && pwrite && pstrb[0];
  assign apb_rd   = psel && !penable && !pwrite;

  function automatic logic is_mapped(input logic [7:0] a);
    is_mapped = (a == stack_top_pointer_addr) || (a == pointer0_low_addr) ||
                (a == pointer0_high_addr) || (a == pointer1_low_addr) ||
                (a == pointer1_high_addr) || (a == power_and_write_mode_control_addr) ||
                (a == active_pointer_select_addr) || (a == paged_data_upper_byte_addr) ||
                (a == processor_status_flags_addr) ||
                (a == accumulator_register_addr) || (a == multiply_helper_addr);
  endfunction

  function automatic logic sw_wr(input logic [7:0] a, input logic we, input logic [7:0] ra);
    sw_wr = we && (ra == a);
  endfunction

  assign mapped = is_mapped(reg_addr) && (paddr[11:10] == 2'b00);

  always_comb begin
    next_rdata = 8'h00;
    unique case (reg_addr)
      stack_top_pointer_addr:            next_rdata = stack_top_pointer;
      pointer0_low_addr:                 next_rdata = pointer0_low;
      pointer0_high_addr:                next_rdata = pointer0_high;
      pointer1_low_addr:                 next_rdata = pointer1_low;
      pointer1_high_addr:                next_rdata = pointer1_high;
      power_and_write_mode_control_addr: next_rdata = power_and_write_mode_control;
      active_pointer_select_addr:        next_rdata = {7'h00, active_pointer_select};
      paged_data_upper_byte_addr:        next_rdata = paged_data_upper_byte;
      processor_status_flags_addr:       next_rdata = o_status;
      accumulator_register_addr:         next_rdata = accumulator_register;
      multiply_helper_addr:              next_rdata = multiply_helper;
      default:                           next_rdata = 8'h00;
    endcase
  end

  // No wait state: read data is latched in setup, ready in the first access cycle
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !mapped;
      if (apb_rd) begin
        prdata <= {24'h00_0000, mapped ? next_rdata : 8'h00};
      end
    end
  end

  logic apb_commit;
  assign apb_commit = apb_wr && pready && mapped;

  // ==========================================================
  // Accumulator and helper; software write wins over the core
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      accumulator_register <= reg_reset;
    end else if (sw_wr(accumulator_register_addr, apb_commit, reg_addr)) begin
      accumulator_register <= wbyte;
    end else if (i_acc_we) begin
      accumulator_register <= i_acc_wdata;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      multiply_helper <= reg_reset;
    end else if (sw_wr(multiply_helper_addr, apb_commit, reg_addr)) begin
      multiply_helper <= wbyte;
    end else if (i_helper_we) begin
      multiply_helper <= i_helper_wdata;
    end
  end

  // ==========================================================
  // Status flags; parity bit is never stored
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      status_bits <= reg_reset;
    end else if (sw_wr(processor_status_flags_addr, apb_commit, reg_addr)) begin
      status_bits <= {wbyte[7:1], 1'b0};
    end else begin
      if (i_carry_we) status_bits[carry_pos] <= i_carry_in;
      if (i_half_carry_we) status_bits[half_carry_pos] <= i_half_carry_in;
      if (i_overflow_we) status_bits[overflow_pos] <= i_overflow_in;
    end
  end

  logic [7:0] status_view;
  logic [7:0] next_acc;
  assign next_acc = (sw_wr(accumulator_register_addr, apb_commit, reg_addr)) ? wbyte :
                    i_acc_we ? i_acc_wdata : accumulator_register;
  // Parity here tracks the accumulator value it holds now; o_status takes it from next_acc
  assign status_view = {status_bits[7:1], ^accumulator_register};

  // ==========================================================
  // Stack pointer
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      stack_top_pointer <= stack_reset;
    end else if (sw_wr(stack_top_pointer_addr, apb_commit, reg_addr)) begin
      stack_top_pointer <= wbyte;
    end else if (i_push && !i_pop) begin
      stack_top_pointer <= stack_top_pointer + 8'h01;
    end else if (i_pop && !i_push) begin
      stack_top_pointer <= stack_top_pointer - 8'h01;
    end
  end

  // ==========================================================
  // Data pointers, select, page and power control
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      pointer0_low  <= reg_reset;
      pointer0_high <= reg_reset;
      pointer1_low  <= reg_reset;
      pointer1_high <= reg_reset;
    end else begin
      if (sw_wr(pointer0_low_addr, apb_commit, reg_addr)) pointer0_low <= wbyte;
      if (sw_wr(pointer0_high_addr, apb_commit, reg_addr)) pointer0_high <= wbyte;
      if (sw_wr(pointer1_low_addr, apb_commit, reg_addr)) pointer1_low <= wbyte;
      if (sw_wr(pointer1_high_addr, apb_commit, reg_addr)) pointer1_high <= wbyte;
      // A 16-bit core update lands only in the active pointer
      if (i_ptr_we && !apb_commit) begin
        if (active_pointer_select) begin
          {pointer1_high, pointer1_low} <= i_ptr_wdata;
        end else begin
          {pointer0_high, pointer0_low} <= i_ptr_wdata;
        end
      end
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      active_pointer_select        <= 1'b0;
      paged_data_upper_byte        <= reg_reset;
      power_and_write_mode_control <= reg_reset;
    end else begin
      if (sw_wr(active_pointer_select_addr, apb_commit, reg_addr)) begin
        active_pointer_select <= wbyte[0];
      end
      if (sw_wr(paged_data_upper_byte_addr, apb_commit, reg_addr)) begin
        paged_data_upper_byte <= wbyte;
      end
      if (sw_wr(power_and_write_mode_control_addr, apb_commit, reg_addr)) begin
        // Bits 1:0 are forced clear so stray writes cannot stick
        power_and_write_mode_control <= wbyte & power_ctl_mask;
      end
    end
  end

  // ==========================================================
  // Internal RAM: banks, bit area, upper half indirect only
  logic [7:0] work_addr;
  logic       ram_hit;
  logic [7:0] bit_byte;
  assign work_addr = {3'b000, status_bits[bank_hi_pos:bank_lo_pos], i_work_reg_sel};
  // Direct addresses at 0x80 and up belong to the register area
  assign ram_hit   = i_ram_indirect || (i_ram_addr < upper_ram_base);
  assign bit_byte  = bit_area_base + {4'h0, i_bit_addr[6:3]};

  always_ff @(posedge i_mclk) begin
    if (i_ram_we && ram_hit) begin
      internal_data_ram[i_ram_addr] <= i_ram_wdata;
    end else if (i_bit_we) begin
      internal_data_ram[bit_byte][i_bit_addr[2:0]] <= i_bit_wdata;
    end
  end

  // ==========================================================
  // Registered outputs to the execution unit
  logic [15:0] active_ptr;
  assign active_ptr = active_pointer_select ? {pointer1_high, pointer1_low}
                                            : {pointer0_high, pointer0_low};

  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      o_ram_rdata             <= 8'h00;
      o_bit_rdata             <= 1'b0;
      o_work_reg_addr         <= 8'h00;
      o_accumulator           <= 8'h00;
      o_helper                <= 8'h00;
      o_status                <= 8'h00;
      o_stack_top             <= stack_reset;
      o_active_data_pointer   <= 16'h0000;
      o_paged_external_data   <= 16'h0000;
      o_external_move_to_code <= 1'b0;
      o_baud_double           <= 1'b0;
    end else begin
      o_ram_rdata             <= ram_hit ? internal_data_ram[i_ram_addr] : 8'h00;
      o_bit_rdata             <= internal_data_ram[bit_byte][i_bit_addr[2:0]];
      o_work_reg_addr         <= work_addr;
      o_accumulator           <= next_acc;
      o_helper                <= multiply_helper;
      o_status                <= {status_view[7:1], ^next_acc};
      o_stack_top             <= stack_top_pointer;
      o_active_data_pointer   <= active_ptr;
      // Low byte is the contents of work register 0 or 1 of the current bank
      o_paged_external_data   <= {paged_data_upper_byte,
                                  internal_data_ram[{3'b000, status_bits[bank_hi_pos:bank_lo_pos],
                                                     2'b00, i_paged_sel_one}]};
      o_external_move_to_code <= power_and_write_mode_control[code_write_pos];
      o_baud_double           <= power_and_write_mode_control[baud_double_pos];
    end
  end

  // ==========================================================
  // Checks
  parity_live_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
    o_status[0] == ^o_accumulator) else $error("parity flag mismatch");
  push_step_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
    i_push && !i_pop && !apb_commit |=> stack_top_pointer == $past(stack_top_pointer) + 8'h01)
    else $error("push did not advance stack");
  pop_step_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
    i_pop && !i_push && !apb_commit |=> stack_top_pointer == $past(stack_top_pointer) - 8'h01)
    else $error("pop did not retreat stack");
  power_low_zero_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
    power_and_write_mode_control[1:0] == 2'b00) else $error("power bits 1:0 set");
  pointer_choice_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
    ##1 o_active_data_pointer == ($past(active_pointer_select) ?
      $past({pointer1_high, pointer1_low}) : $past({pointer0_high, pointer0_low})))
    else $error("wrong active pointer");
  code_steer_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
    ##1 o_external_move_to_code == $past(power_and_write_mode_control[code_write_pos]))
    else $error("code steer mismatch");
  bank_addr_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
    ##1 o_work_reg_addr[7:5] == 3'b000 && o_work_reg_addr[4:3] == $past(status_bits[4:3]))
    else $error("bank address wrong");
  page_write_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
    sw_wr(paged_data_upper_byte_addr, apb_commit, reg_addr)
      |=> ##1 o_paged_external_data[15:8] == $past(wbyte, 2))
    else $error("page byte not applied");
  select_zero_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
    apb_rd && reg_addr == active_pointer_select_addr |=> prdata[31:1] == 31'h0)
    else $error("select unused bits nonzero");
  carry_take_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
    i_carry_we && !apb_commit |=> status_bits[carry_pos] == $past(i_carry_in))
    else $error("carry not taken");
endmodule
`default_nettype wire

// File: testbench/exec_unit_model.sv
// Behavioural model of the instruction execution unit on the core side
`timescale 1ns/100ps
`default_nettype none
module exec_unit_model (
  input  wire logic        i_mclk,
  output logic             o_ram_we,
  output logic             o_ram_indirect,
  output logic [7:0]       o_ram_addr,
  output logic [7:0]       o_ram_wdata,
  output logic             o_bit_we,
  output logic [6:0]       o_bit_addr,
  output logic             o_bit_wdata,
  output logic [2:0]       o_work_reg_sel,
  output logic             o_acc_we,
  output logic [7:0]       o_acc_wdata,
  output logic             o_helper_we,
  output logic [7:0]       o_helper_wdata,
  output logic             o_carry_we,
  output logic             o_carry_in,
  output logic             o_half_carry_we,
  output logic             o_half_carry_in,
  output logic             o_overflow_we,
  output logic             o_overflow_in,
  output logic             o_push,
  output logic             o_pop,
  output logic             o_ptr_we,
  output logic [15:0]      o_ptr_wdata,
  output logic             o_paged_sel_one
);
  // ==========================================================
  // Idle state
  initial begin
    {o_ram_we, o_ram_indirect, o_ram_addr, o_ram_wdata, o_bit_we, o_bit_addr} = '0;
    {o_bit_wdata, o_work_reg_sel, o_acc_we, o_acc_wdata, o_helper_we, o_helper_wdata} = '0;
    {o_carry_we, o_carry_in, o_half_carry_we, o_half_carry_in, o_overflow_we} = '0;
    {o_overflow_in, o_push, o_pop, o_ptr_we, o_ptr_wdata, o_paged_sel_one} = '0;
  end
  // ==========================================================
  // One operation: a random stall, a one-cycle strobe, a quiet cycle
  // The quiet cycle keeps back-to-back calls from assigning a strobe twice
  task automatic op(input int k, input logic [7:0] a, input logic [15:0] d);
    repeat ($urandom_range(2, 0)) @(posedge i_mclk);
    case (k)
      0: {o_ram_we, o_ram_indirect, o_ram_addr, o_ram_wdata} <= {1'b1, d[8], a, d[7:0]};
      1: {o_ram_indirect, o_ram_addr} <= {d[8], a};
      2: {o_bit_we, o_bit_addr, o_bit_wdata} <= {1'b1, a[6:0], d[0]};
      3: {o_acc_we, o_acc_wdata} <= {1'b1, d[7:0]};
      4: {o_helper_we, o_helper_wdata} <= {1'b1, d[7:0]};
      5: {o_carry_we, o_carry_in, o_half_carry_we, o_half_carry_in, o_overflow_we,
          o_overflow_in} <= {1'b1, d[2], 1'b1, d[1], 1'b1, d[0]};
      6: o_push <= 1'b1;
      7: o_pop <= 1'b1;
      8: {o_ptr_we, o_ptr_wdata} <= {1'b1, d};
      default: {o_work_reg_sel, o_paged_sel_one} <= {a[2:0], d[0]};
    endcase
    @(posedge i_mclk);
    {o_ram_we, o_bit_we, o_acc_we, o_helper_we, o_push, o_pop, o_ptr_we} <= '0;
    {o_carry_we, o_half_carry_we, o_overflow_we} <= '0;
    @(posedge i_mclk);
  endtask
endmodule
`default_nettype wire

// File: testbench/test_core_regs.sv
// Self-checking bench for the core register set
`timescale 1ns/100ps
`default_nettype none
module test_core_regs
  import core_regs_pkg::*;
;
  typedef struct packed {logic w; logic e; logic [7:0] d;} apb_note_s;
  localparam logic [7:0] reg_map [11] = '{stack_top_pointer_addr, pointer0_low_addr,
    pointer0_high_addr, pointer1_low_addr, pointer1_high_addr,
    power_and_write_mode_control_addr, active_pointer_select_addr, paged_data_upper_byte_addr,
    processor_status_flags_addr, accumulator_register_addr, multiply_helper_addr};
  logic             i_mclk = 1'b0;
  logic             i_sys_rst, psel, penable, pwrite;
  logic [11:0]      paddr;
  logic [31:0]      pwdata;
  logic [3:0]       pstrb;
  wire logic        pready, pslverr;
  wire logic [31:0] prdata;
  wire logic        i_ram_we, i_ram_indirect, i_bit_we, i_bit_wdata, i_acc_we, i_helper_we;
  wire logic        i_carry_we, i_carry_in, i_half_carry_we, i_half_carry_in, i_overflow_we;
  wire logic        i_overflow_in, i_push, i_pop, i_ptr_we, i_paged_sel_one;
  wire logic [7:0]  i_ram_addr, i_ram_wdata, i_acc_wdata, i_helper_wdata;
  wire logic [6:0]  i_bit_addr;
  wire logic [2:0]  i_work_reg_sel;
  wire logic [15:0] i_ptr_wdata, o_active_data_pointer, o_paged_external_data;
  wire logic [7:0]  o_ram_rdata, o_work_reg_addr, o_accumulator, o_helper, o_status, o_stack_top;
  wire logic        o_bit_rdata, o_external_move_to_code, o_baud_double;
  int               fails = 0;
  int               check_count = 0;
  int               cycle_count = 0;
  logic [7:0]       wv [11];
  logic [7:0]       v, a;
  logic [15:0]      p;
  apb_note_s        notes [$];
  apb_note_s        note;

  always #5 i_mclk = ~i_mclk;

  core_regs i_core_regs (.i_mclk, .i_sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pstrb, .pready, .prdata, .pslverr, .i_ram_we, .i_ram_indirect, .i_ram_addr, .i_ram_wdata,
    .i_bit_we, .i_bit_addr, .i_bit_wdata, .i_work_reg_sel, .i_acc_we, .i_acc_wdata,
    .i_helper_we, .i_helper_wdata, .i_carry_we, .i_carry_in, .i_half_carry_we,
    .i_half_carry_in, .i_overflow_we, .i_overflow_in, .i_push, .i_pop, .i_ptr_we, .i_ptr_wdata,
    .i_paged_sel_one, .o_ram_rdata, .o_bit_rdata, .o_work_reg_addr, .o_accumulator, .o_helper,
    .o_status, .o_stack_top, .o_active_data_pointer, .o_paged_external_data,
    .o_external_move_to_code, .o_baud_double);
  exec_unit_model i_exec_unit_model (.i_mclk(i_mclk), .o_ram_we(i_ram_we),
    .o_ram_indirect(i_ram_indirect), .o_ram_addr(i_ram_addr), .o_ram_wdata(i_ram_wdata),
    .o_bit_we(i_bit_we), .o_bit_addr(i_bit_addr), .o_bit_wdata(i_bit_wdata),
    .o_work_reg_sel(i_work_reg_sel), .o_acc_we(i_acc_we), .o_acc_wdata(i_acc_wdata),
    .o_helper_we(i_helper_we), .o_helper_wdata(i_helper_wdata), .o_carry_we(i_carry_we),
    .o_carry_in(i_carry_in), .o_half_carry_we(i_half_carry_we),
    .o_half_carry_in(i_half_carry_in), .o_overflow_we(i_overflow_we),
    .o_overflow_in(i_overflow_in), .o_push(i_push), .o_pop(i_pop), .o_ptr_we(i_ptr_we),
    .o_ptr_wdata(i_ptr_wdata), .o_paged_sel_one(i_paged_sel_one));

  // ==========================================================
  // Checking and closing
  task automatic cmp_bus(input logic [32:0] act, input logic [32:0] exp);
    check_count++;
    if (act !== exp) begin
      fails++;
      $display("[ERR] %0t bus answer %h expected %h", $time, act, exp);
    end
  endtask
  task automatic cmp_core(input logic [15:0] act, input logic [15:0] exp);
    check_count++;
    if (act !== exp) begin
      fails++;
      $display("[ERR] %0t core output %h expected %h", $time, act, exp);
    end
  endtask
  task automatic stop_test();
    if (fails == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  always @(posedge i_mclk) begin
    cycle_count++;
    if (cycle_count == 5000) begin
      fails++;
      stop_test();
    end
  end
  // Watcher takes the oldest note for every completed transfer
  always @(posedge i_mclk) begin
    if (psel && penable && pready === 1'b1 && notes.size() > 0) begin
      note = notes.pop_front();
      cmp_bus({pslverr, (note.w ? 32'h0 : prdata)}, {note.e, 24'h0, note.d});
    end
  end

  // ==========================================================
  // Bus master and helpers
  task automatic apb(input logic w, input logic [7:0] off, input logic [7:0] d,
                     input logic [7:0] exp, input logic e);
    notes.push_back({w, e, exp});
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, 2'b00, off, 2'b00, 24'h0, d};
    @(posedge i_mclk);
    penable <= 1'b1;
    @(posedge i_mclk);
    while (pready !== 1'b1) @(posedge i_mclk);
    {psel, penable} <= 2'b00;
    @(posedge i_mclk);
  endtask
  task automatic settle();
    repeat (3) @(posedge i_mclk);
  endtask

  // ==========================================================
  // Scenarios
  initial begin
    void'($urandom(32'ha2e6d8e1));
    {i_sys_rst, psel, penable, pwrite, paddr, pwdata} = {1'b1, 47'h0};
    pstrb = 4'hf;
    repeat (4) @(posedge i_mclk);
    i_sys_rst <= 1'b0;
    @(posedge i_mclk);
    for (int k = 0; k < 11; k++) begin
      apb(1'b0, reg_map[k], 8'h00, (k == 0) ? stack_reset : reg_reset, 1'b0);
    end
    for (int k = 0; k < 11; k++) begin
      wv[k] = 8'($urandom);
      if (!(k inside {5, 6, 8})) begin
        apb(1'b1, reg_map[k], wv[k], 8'h00, 1'b0);
        apb(1'b0, reg_map[k], 8'h00, wv[k], 1'b0);
      end
    end
    settle();
    cmp_core({o_accumulator, o_helper}, {wv[9], wv[10]});
    cmp_core(o_active_data_pointer, {wv[2], wv[1]});
    // Low power bits are always written clear and must read back clear
    apb(1'b1, reg_map[5], 8'hfc, 8'h00, 1'b0);
    apb(1'b0, reg_map[5], 8'h00, 8'hfc, 1'b0);
    cmp_core({14'h0, o_baud_double, o_external_move_to_code}, 16'h0003);
    apb(1'b1, reg_map[5], 8'h10, 8'h00, 1'b0);
    apb(1'b0, reg_map[5], 8'h00, 8'h10, 1'b0);
    cmp_core({14'h0, o_baud_double, o_external_move_to_code}, 16'h0001);
    apb(1'b1, reg_map[6], 8'hff, 8'h00, 1'b0);
    apb(1'b0, reg_map[6], 8'h00, 8'h01, 1'b0);
    cmp_core(o_active_data_pointer, {wv[4], wv[3]});
    p = 16'($urandom);
    i_exec_unit_model.op(8, 8'h00, p);
    apb(1'b0, reg_map[3], 8'h00, p[7:0], 1'b0);
    apb(1'b0, reg_map[4], 8'h00, p[15:8], 1'b0);
    apb(1'b1, reg_map[6], 8'h00, 8'h00, 1'b0);
    settle();
    cmp_core(o_active_data_pointer, {wv[2], wv[1]});
    for (int b = 0; b < 4; b++) begin
      v = 8'($urandom);
      v[4:3] = 2'(b);
      apb(1'b1, reg_map[8], v, 8'h00, 1'b0);
      apb(1'b0, reg_map[8], 8'h00, {v[7:1], ^wv[9]}, 1'b0);
      a = 8'($urandom);
      i_exec_unit_model.op(9, a, 16'h0001);
      settle();
      cmp_core({8'h00, o_work_reg_addr}, {11'h0, 2'(b), a[2:0]});
    end
    v = 8'($urandom);
    i_exec_unit_model.op(0, 8'h19, {8'h00, v});
    settle();
    cmp_core(o_paged_external_data, {wv[7], v});
    i_exec_unit_model.op(0, 8'h21, 16'h0000);
    i_exec_unit_model.op(2, 8'h0b, 16'h0001);
    i_exec_unit_model.op(1, 8'h21, 16'h0000);
    settle();
    cmp_core({7'h0, o_bit_rdata, o_ram_rdata}, 16'h0108);
    i_exec_unit_model.op(0, 8'h90, {8'h01, v});
    i_exec_unit_model.op(1, 8'h90, 16'h0100);
    settle();
    cmp_core({8'h00, o_ram_rdata}, {8'h00, v});
    i_exec_unit_model.op(1, 8'h90, 16'h0000);
    settle();
    cmp_core({8'h00, o_ram_rdata}, 16'h0000);
    a = 8'($urandom);
    i_exec_unit_model.op(3, 8'h00, {8'h00, a});
    i_exec_unit_model.op(4, 8'h00, {8'h00, ~a});
    for (int f = 2; f <= 5; f += 3) begin
      i_exec_unit_model.op(5, 8'h00, 16'(f));
      settle();
      cmp_core({o_accumulator, o_helper}, {a, ~a});
      cmp_core({12'h0, o_status[7], o_status[6], o_status[2], o_status[0]},
               {12'h0, 3'(f), ^a});
    end
    i_exec_unit_model.op(6, 8'h00, 16'h0000);
    settle();
    cmp_core({8'h00, o_stack_top}, {8'h00, wv[0] + 8'h01});
    i_exec_unit_model.op(7, 8'h00, 16'h0000);
    i_exec_unit_model.op(7, 8'h00, 16'h0000);
    apb(1'b0, reg_map[0], 8'h00, wv[0] - 8'h01, 1'b0);
    pstrb <= 4'he;
    apb(1'b1, reg_map[9], ~a, 8'h00, 1'b0);
    pstrb <= 4'hf;
    apb(1'b0, reg_map[9], 8'h00, a, 1'b0);
    apb(1'b1, 8'h86, 8'h55, 8'h00, 1'b1);
    apb(1'b0, 8'h86, 8'h00, 8'h00, 1'b1);
    stop_test();
  end
endmodule
`default_nettype wire
